// [hdl/idle_sleep_pkg.sv]
// Package with constants and types for the light-load sleep timer.
package idle_sleep_pkg;

    // ------------------------------------------------------------------
    // Clock and interval settings
    // ------------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 25_000_000;
    localparam int unsigned CLK_PER_US  = CLK_FREQ_HZ / 1_000_000;

    // Nominal idle intervals in microseconds, one per selectable setting.
    localparam int unsigned INTERVAL_70_US   = 70;
    localparam int unsigned INTERVAL_130_US  = 130;
    localparam int unsigned INTERVAL_280_US  = 280;
    localparam int unsigned INTERVAL_540_US  = 540;
    localparam int unsigned INTERVAL_1075_US = 1075;

    // Wake-up recovery time in microseconds; a plain default.
    localparam int unsigned WAKE_RECOVERY_US = 10;
    localparam int unsigned WAKE_RECOVERY_CYC =
        (WAKE_RECOVERY_US * CLK_PER_US < 1) ? 1
                                            : WAKE_RECOVERY_US * CLK_PER_US;

    // Width of the idle counter; holds the longest interval in cycles.
    localparam int unsigned CNT_W = 16;

    // ------------------------------------------------------------------
    // Interval selection codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SEL_OFF_DEVICE,
        SEL_70,
        SEL_130,
        SEL_280,
        SEL_540,
        SEL_1075,
        SEL_DETECT_OFF
    } interval_sel_t;

    localparam logic [2:0] SEL_RESET = 3'h6;

    // Nominal interval in clock cycles for a selection code.
    function automatic logic [CNT_W-1:0] nominal_cycles(
        input logic [2:0] sel
    );
        int unsigned us;
        us = 0;
        unique case (sel)
            3'h1:    us = INTERVAL_70_US;
            3'h2:    us = INTERVAL_130_US;
            3'h3:    us = INTERVAL_280_US;
            3'h4:    us = INTERVAL_540_US;
            3'h5:    us = INTERVAL_1075_US;
            default: us = INTERVAL_1075_US;
        endcase
        return CNT_W'(us * CLK_PER_US);
    endfunction

endpackage

// [hdl/idle_sense_if.sv]
// Interface carrying conduction events from the sense stage to the timer.
`timescale 1ns/100ps
interface idle_sense_if;
    logic conducting;
    logic cond_start;
    logic cond_end;

    modport src (
        output conducting,
        output cond_start,
        output cond_end
    );
    modport dst (
        input  conducting,
        input  cond_start,
        input  cond_end
    );
endinterface

// [hdl/idle_sense_sync.sv]
// Synchroniser and edge detector for the current-sense sign input.
`timescale 1ns/100ps
module idle_sense_sync (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    // Raw sign of the sensed voltage, high when negative
    input  wire logic cs_negative,
    // Conduction events
    idle_sense_if.src sense
);

    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= cs_negative;
            sync_q <= meta_q;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= sync_q;
        end
    end

    // Negative sense voltage means the rectifier or its diode conducts.
    assign sense.conducting = sync_q;
    assign sense.cond_start = sync_q & ~prev_q;
    assign sense.cond_end   = ~sync_q & prev_q;

endmodule

// [hdl/light_load_sleep_timer.sv]
// Idle-detection sleep timer for a synchronous-rectifier controller.
// What this block does
// - A negative sensed voltage means conduction, a positive one none.
// - The idle timer counts while the controller is active and there is no conduction.
// - Reaching the current length sets the sleep flag.
// - Expiry also clears the timer and halves its length.
// - Asleep, a conduction start clears sleep and begins wake recovery.
// - After a wake, the rectifier drive is enabled only after recovery completes.
// - The timer restarts at the end of each conduction phase.
// - A new phase under a quarter interval only resets the timer.
// - Full length returns only for a phase between quarter and half.
// - Interval is 70..1075 us; lowest code turns the device off, highest disables detection.
// - Supply-up or device off returns the controller to its start state.
// - Fast-slope and exception-timer options are never both enabled.
`timescale 1ns/100ps
module light_load_sleep_timer #(
    parameter bit SLOPE_OPTION     = 1'b0,
    parameter bit EXCEPTION_OPTION = 1'b0
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // Sensed voltage sign, high when negative
    input  wire logic       cs_negative,
    // Configuration
    input  wire logic [2:0] interval_sel,
    input  wire logic       external_off_input,
    // Status
    output logic            sleep_flag,
    output logic            sync_rectifier_enable,
    output logic            restart_pulse,
    output logic            half_length
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // Both options share decision logic, so a build with both is refused.
    if (SLOPE_OPTION && EXCEPTION_OPTION) begin : g_opt_check
        $error("slope and exception options cannot both be enabled");
    end

    typedef enum logic [1:0] {
        ST_START,
        ST_ACTIVE,
        ST_SLEEP,
        ST_WAKE
    } state_t;

    // ------------------------------------------------------------------
    // Sense stage
    // ------------------------------------------------------------------
    idle_sense_if sense ();

    idle_sense_sync u_sync (
        .sys_clk     (sys_clk),
        .resetn      (resetn),
        .cs_negative (cs_negative),
        .sense       (sense)
    );

    // ------------------------------------------------------------------
    // Configuration capture
    // ------------------------------------------------------------------
    logic [2:0] sel_meta_q;
    logic [2:0] sel_q;
    logic       off_meta_q;
    logic       off_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sel_meta_q <= idle_sleep_pkg::SEL_RESET;
            sel_q      <= idle_sleep_pkg::SEL_RESET;
            off_meta_q <= 1'b0;
            off_q      <= 1'b0;
        end else begin
            sel_meta_q <= interval_sel;
            sel_q      <= sel_meta_q;
            off_meta_q <= external_off_input;
            off_q      <= off_meta_q;
        end
    end

    logic device_off;
    logic detect_off;
    assign device_off = (sel_q == 3'h0) || off_q;
    // Codes beyond the table read as an open input.
    assign detect_off = (sel_q >= 3'h6);

    // ------------------------------------------------------------------
    // Limits derived from the nominal interval
    // ------------------------------------------------------------------
    logic [idle_sleep_pkg::CNT_W-1:0] full_cnt;
    logic [idle_sleep_pkg::CNT_W-1:0] half_cnt;
    logic [idle_sleep_pkg::CNT_W-1:0] quarter_cnt;
    logic [idle_sleep_pkg::CNT_W-1:0] limit;

    assign full_cnt    = idle_sleep_pkg::nominal_cycles(sel_q);
    assign half_cnt    = full_cnt >> 1;
    assign quarter_cnt = full_cnt >> 2;

    logic half_q;
    assign limit = half_q ? half_cnt : full_cnt;

    // ------------------------------------------------------------------
    // State machine and idle counter
    // ------------------------------------------------------------------
    state_t state_q;
    logic [idle_sleep_pkg::CNT_W-1:0] idle_cnt_q;
    logic [idle_sleep_pkg::CNT_W-1:0] wake_cnt_q;

    logic idle_running;
    logic expired;
    assign idle_running = (state_q == ST_ACTIVE) && !sense.conducting;
    assign expired      = idle_running && !detect_off
                          && (idle_cnt_q + 1'b1 >= limit);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_START;
        end else if (device_off) begin
            state_q <= ST_START;
        end else begin
            unique case (state_q)
                ST_START: begin
                    state_q <= ST_ACTIVE;
                end
                ST_ACTIVE: begin
                    if (expired) begin
                        state_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (sense.cond_start) begin
                        state_q <= ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (wake_cnt_q == 1'b0) begin
                        state_q <= ST_ACTIVE;
                    end
                end
            endcase
        end
    end

    // Idle counter: runs with no conduction, cleared on every restart.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            idle_cnt_q <= '0;
        end else if (state_q != ST_ACTIVE || expired) begin
            idle_cnt_q <= '0;
        end else if (sense.cond_end || sense.conducting) begin
            idle_cnt_q <= '0;
        end else if (idle_running && idle_cnt_q != '1) begin
            idle_cnt_q <= idle_cnt_q + 1'b1;
        end
    end

    // Length selection gives hysteresis between full and half length.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            half_q <= 1'b0;
        end else if (expired) begin
            half_q <= 1'b1;
        end else if (state_q == ST_ACTIVE && sense.cond_start) begin
            if (idle_cnt_q >= quarter_cnt && idle_cnt_q < half_cnt) begin
                half_q <= 1'b0;
            end // below a quarter keeps the length
        end
    end

    // Recovery counter loaded when sleep ends.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wake_cnt_q <= '0;
        end else if (state_q == ST_SLEEP && sense.cond_start) begin
            wake_cnt_q <= idle_sleep_pkg::CNT_W'(
                idle_sleep_pkg::WAKE_RECOVERY_CYC - 1);
        end else if (state_q == ST_WAKE && wake_cnt_q != '0) begin
            wake_cnt_q <= wake_cnt_q - 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The pulse that ends sleep never turns the drive on directly.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sleep_flag            <= 1'b0;
            sync_rectifier_enable <= 1'b0;
            restart_pulse         <= 1'b0;
            half_length           <= 1'b0;
        end else begin
            sleep_flag            <= (state_q == ST_SLEEP && !sense.cond_start)
                                     || expired;
            sync_rectifier_enable <= (state_q == ST_ACTIVE) && !expired
                                     && !device_off;
            restart_pulse         <= expired || device_off;
            half_length           <= half_q;
        end
    end

endmodule

// [testbench/sleep_timer_monitor.sv]
// Port assertions for the light-load sleep timer.
`timescale 1ns/100ps
module sleep_timer_monitor (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       resetn,
    // Inputs
    input wire logic       cs_negative,
    input wire logic [2:0] interval_sel,
    input wire logic       external_off_input,
    // Outputs
    input wire logic       sleep_flag,
    input wire logic       sync_rectifier_enable,
    input wire logic       restart_pulse,
    input wire logic       half_length
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    chk_sleep_no_drive: assert property (
        sleep_flag |-> !sync_rectifier_enable) else $error("drive on asleep");
    chk_wake_no_drive: assert property (
        $fell(sleep_flag) |-> !sync_rectifier_enable [*8])
        else $error("drive on at wake");
    chk_sleep_halves: assert property (
        $rose(sleep_flag) |-> ##[0:1] half_length) else $error("no half");
    chk_sleep_restart: assert property (
        $rose(sleep_flag) |-> restart_pulse || $past(restart_pulse)
            || $past(restart_pulse, 2)) else $error("no restart");
    chk_sleep_holds: assert property (
        (!cs_negative && !external_off_input) [*4] ##0 sleep_flag
            |=> sleep_flag) else $error("sleep dropped");
    chk_wake_bound: assert property (
        cs_negative [*2] ##0 sleep_flag |-> ##[1:4] !sleep_flag)
        else $error("no wake");
    chk_idle_before: assert property (
        $rose(sleep_flag) |-> !$past(cs_negative, 4))
        else $error("sleep while conducting");
    chk_detect_off: assert property (
        (interval_sel[2:1] == 2'h3) [*4] |-> !$rose(sleep_flag))
        else $error("sleep with detection off");
    chk_device_off: assert property (
        (interval_sel == 3'h0) [*4] |-> !sync_rectifier_enable)
        else $error("drive on with device off");
    cover property ($rose(sleep_flag));
    cover property ($fell(sleep_flag));
    cover property ($fell(half_length));
endmodule

// [testbench/sense_model.sv]
// Current-sense comparator model producing conduction pulses.
`timescale 1ns/100ps
module sense_model (
    // Clock
    input wire logic        sys_clk,
    // Pulse request from the bench
    input wire logic        go,
    input wire logic [15:0] len,
    // Comparator output, high while the rectifier conducts
    output logic            cs_negative
);
    logic [15:0] left_q = 16'h0;
    always_ff @(posedge sys_clk) begin
        if (go) begin
            left_q <= len;
        end else if (left_q != 16'h0) begin
            left_q <= left_q - 16'h1;
        end
    end
    // The comparator is always powered, so it reads low between pulses.
    assign cs_negative = (left_q != 16'h0);
endmodule

// [testbench/light_load_sleep_timer_bench.sv]
// Self-checking bench for the light-load sleep timer.
`timescale 1ns/100ps
module light_load_sleep_timer_bench;
    localparam int N = 1750;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        cs_negative;
    logic [2:0]  interval_sel = 3'h1;
    logic        external_off_input = 1'b0;
    logic        sleep_flag;
    logic        sync_rectifier_enable;
    logic        restart_pulse;
    logic        half_length;
    logic        go = 1'b0;
    logic [15:0] len = 16'h0;
    int          num_errors = 0;
    int          checks = 0;
    always #20 sys_clk = ~sys_clk;
    light_load_sleep_timer dut (.sys_clk, .resetn, .cs_negative,
        .interval_sel, .external_off_input, .sleep_flag,
        .sync_rectifier_enable, .restart_pulse, .half_length);
    sense_model model (.sys_clk, .go, .len, .cs_negative);
    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(string what, logic exp, logic got);
        checks++;
        if (got !== exp) begin
            $display("BAD %s expected %b seen %b", what, exp, got);
            num_errors++;
        end
    endtask
    task automatic pulse(int n);
        go <= 1'b1;
        len <= 16'(n);
        @(posedge sys_clk);
        go <= 1'b0;
        cyc(n);
    endtask
    task automatic wait_sleep(int lim);
        repeat (lim) if (sleep_flag !== 1'b1) @(posedge sys_clk);
    endtask
    task automatic wait_enable(int lim);
        repeat (lim) if (sync_rectifier_enable !== 1'b1) @(posedge sys_clk);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic t_expire(int len_cyc);
        pulse(20);
        cyc(len_cyc - 30);
        chk("sleep early", 1'b0, sleep_flag);
        wait_sleep(60);
        chk("sleep", 1'b1, sleep_flag);
        chk("restart expiry", 1'b1, restart_pulse);
        cyc(1);
        chk("half", 1'b1, half_length);
        chk("enable asleep", 1'b0, sync_rectifier_enable);
    endtask
    task automatic t_wake;
        pulse(40);
        chk("sleep woken", 1'b0, sleep_flag);
        chk("enable wake", 1'b0, sync_rectifier_enable);
        cyc(180);
        chk("enable recovery", 1'b0, sync_rectifier_enable);
        cyc(60);
        chk("enable after", 1'b1, sync_rectifier_enable);
    endtask
    task automatic t_gaps;
        pulse(20);
        cyc(300);
        pulse(20);
        chk("half short gap", 1'b1, half_length);
        cyc(600);
        pulse(20);
        chk("half mid gap", 1'b0, half_length);
        cyc(1000);
        chk("sleep full length", 1'b0, sleep_flag);
        wait_sleep(900);
        chk("sleep full", 1'b1, sleep_flag);
    endtask
    task automatic t_config;
        interval_sel <= 3'h6;
        cyc(N + 100);
        chk("detect off", 1'b0, sleep_flag);
        interval_sel <= 3'h0;
        cyc(10);
        chk("device off", 1'b0, sync_rectifier_enable);
        chk("restart device off", 1'b1, restart_pulse);
        interval_sel <= 3'h1;
        external_off_input <= 1'b1;
        cyc(10);
        chk("external off", 1'b0, sync_rectifier_enable);
        external_off_input <= 1'b0;
        wait_enable(400);
        chk("external back", 1'b1, sync_rectifier_enable);
    endtask
    initial begin
        cyc(10);
        resetn <= 1'b1;
        cyc(10);
        chk("start enable", 1'b1, sync_rectifier_enable);
        chk("start half", 1'b0, half_length);
        t_expire(N);
        t_wake();
        t_gaps();
        t_wake();
        t_expire(N / 2);
        t_wake();
        t_config();
        finish_test();
    end
    initial begin
        cyc(30000);
        num_errors++;
        finish_test();
    end
endmodule
bind light_load_sleep_timer sleep_timer_monitor mon (.sys_clk, .resetn,
    .cs_negative, .interval_sel, .external_off_input, .sleep_flag,
    .sync_rectifier_enable, .restart_pulse, .half_length);
